// ==== hdl/tcaio_curve.sv ====
// Piecewise linear curve evaluation over a point table
`timescale 1ns/1ns
module tcaio_curve #(
   parameter int VW = 16,
   parameter int NP = 32,
   parameter int IW = 5
) (
   input wire logic signed [VW-1:0] x,
   input wire logic [NP*VW-1:0] px,
   input wire logic [NP*VW-1:0] py,
   input wire logic [IW:0] npts,
   output logic signed [VW-1:0] y
);
   logic [IW-1:0] seg;
   logic signed [VW-1:0] x0, x1, y0, y1;
   logic signed [2*VW+1:0] num;
   logic signed [VW:0] dx;

   always_comb begin
      seg = '0;
      // Pick the last segment whose start lies at or below x; ends extend outward
      for (int i = 1; i < NP - 1; i++) begin
         if (i < int'(npts) - 1 && $signed(px[i*VW +: VW]) <= x) begin
            seg = IW'(i);
         end
      end
      x0 = $signed(px[int'(seg)*VW +: VW]);
      y0 = $signed(py[int'(seg)*VW +: VW]);
      x1 = $signed(px[(int'(seg)+1)*VW +: VW]);
      y1 = $signed(py[(int'(seg)+1)*VW +: VW]);
      dx = (VW+1)'(x1) - (VW+1)'(x0);
      num = (2*VW+2)'((VW+1)'(y1) - (VW+1)'(y0)) * (2*VW+2)'((VW+1)'(x) - (VW+1)'(x0));
      if (npts < 2) begin
         y = (npts == 0) ? x : y0;
      end else if (dx == 0) begin
         y = y0;
      end else begin
         y = VW'(num / dx + (2*VW+2)'(y0));
      end
   end
endmodule

// ==== hdl/tcaio_pkg.sv ====
// Package of constants and types for the threshold, curve and analogue output block
package tcaio_pkg;
   // ----------------------------------------------------------------
   // Widths and sizes
   // ----------------------------------------------------------------
   localparam int VAL_W = 16;
   localparam int CODE_W = 14;
   localparam int NPTS = 32;
   localparam int PIDX_W = 5;
   localparam int DLY_W = 16;
   localparam int NIN = 4;
   localparam int NMEAS = 8;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 10000000;
   localparam int TICK_US = 10000;
   localparam int TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
   localparam int DEF_DELAY_MS = 500;
   localparam int DEF_DELAY_TICKS = (DEF_DELAY_MS * 1000) / TICK_US;
   // ----------------------------------------------------------------
   // Function codes
   // ----------------------------------------------------------------
   localparam logic [CODE_W-1:0] IN_PHYS_MAX = 14'd4000;
   localparam logic [CODE_W-1:0] IN_VIRT_MIN = 14'd4001;
   localparam logic [CODE_W-1:0] OF_UNUSED = 14'd0;
   localparam logic [CODE_W-1:0] OF_SERIAL = 14'd102;
   localparam logic [CODE_W-1:0] OF_GOV = 14'd1000;
   localparam logic [CODE_W-1:0] OF_GOV_C = 14'd1001;
   localparam logic [CODE_W-1:0] OF_AVR = 14'd1002;
   localparam logic [CODE_W-1:0] OF_AVR_C = 14'd1003;
   localparam logic [CODE_W-1:0] OF_BUS_F = 14'd3101;
   localparam logic [CODE_W-1:0] OF_BUS_V = 14'd3111;
   localparam logic [CODE_W-1:0] OF_BUS_P = 14'd3121;
   localparam logic [CODE_W-1:0] OF_MNS_F = 14'd3201;
   localparam logic [CODE_W-1:0] OF_MNS_V = 14'd3211;
   localparam logic [CODE_W-1:0] OF_MNS_P = 14'd3221;
   // ----------------------------------------------------------------
   // Threshold configuration bits; output scale (+-10000 mV)
   // ----------------------------------------------------------------
   localparam int CFG_BELOW = 0;
   localparam int CFG_SET = 1;
   localparam logic signed [VAL_W-1:0] OUT_FULL_MV = 16'sd10000;
   localparam logic signed [VAL_W-1:0] PCT_FULL = 16'sd100;
   localparam logic [7:0] LIM_LO_RST = 8'h00;
   localparam logic [7:0] LIM_HI_RST = 8'h64;
   // ----------------------------------------------------------------
   // Register map (word index = byte address / 4)
   // ----------------------------------------------------------------
   localparam logic [7:0] A_STATUS = 8'h00;
   localparam logic [7:0] A_IRQ_ST = 8'h04;
   localparam logic [7:0] A_IRQ_MASK = 8'h08;
   localparam logic [7:0] A_OFUNC0 = 8'h10;
   localparam logic [7:0] A_OFUNC1 = 8'h14;
   localparam logic [7:0] A_LIM_GOV = 8'h18;
   localparam logic [7:0] A_LIM_AVR = 8'h1c;
   localparam logic [7:0] A_SER0 = 8'h20;
   localparam logic [7:0] A_SER1 = 8'h24;
   localparam logic [7:0] A_OUT0 = 8'h28;
   localparam logic [7:0] A_OUT1 = 8'h2c;
   localparam logic [7:0] A_IFUNC = 8'h40;
   localparam logic [7:0] A_THR = 8'h60;
   localparam logic [7:0] A_CURVE = 8'h80;
   localparam int NCURVE = 2;
   // Irq bits: [NIN-1:0] status rise, [NIN] refused code, [NIN+1] output tick
   localparam int IRQ_W = NIN + 2;

   typedef enum logic [1:0] {
      TCAIO_IDLE = 2'b00,
      TCAIO_IN = 2'b01,
      TCAIO_OUT = 2'b10
   } tcaio_phase_t;
endpackage

// ==== hdl/tcaio_thresh.sv ====
// One threshold with its persistence timer
`timescale 1ns/1ns
module tcaio_thresh #(
   parameter int VW = 16,
   parameter int DW = 16
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic signed [VW-1:0] value,
   input wire logic signed [VW-1:0] level,
   input wire logic [DW-1:0] delay,
   input wire logic below,
   output logic fire
);
   typedef struct packed {
      logic [DW-1:0] cnt;
      logic fire;
   } tcaio_th_t;
   tcaio_th_t s, next_s;
   logic out_cond;

   always_comb begin
      next_s = s;
      out_cond = below ? (value < level) : (value > level);
      next_s.fire = 1'b0;
      if (tick) begin
         if (!out_cond) begin
            next_s.cnt = '0;
         end else if (s.cnt >= delay) begin
            next_s.fire = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign fire = s.fire;

   property p_fire_needs_time;
      @(posedge clk) disable iff (!nrst) s.fire |-> $past(s.cnt) >= $past(delay);
   endproperty
   a_fire_needs_time: assert property (p_fire_needs_time) else $error("fire before delay");
endmodule

// ==== hdl/tcaio_top.sv ====
// Threshold detection, conversion curves and two analogue output channels
`timescale 1ns/1ns
// Summary of operation
// - A physical input configured with a code above 4000 is refused and reads as unused.
// - A virtual input with code 4001 or more copies the internal measurement chosen by it.
// - Every input has two thresholds; config bit 0 picks above (clear) or below (set).
// - Config bit 1 set makes the excursion set the status, clear makes it clear it.
// - An action applies only after the excursion lasts its full delay in ticks.
// - Each input status leaves the block as a logic operand.
// - A curve holds up to 32 point pairs and maps input to output along its segments.
// - Inputs beyond the end points follow the first or last segment outward.
// - Curve 0 may be attached to input 0 or to output one; curve 1 only to output two.
// - Each output spans -10 V to +10 V, except serial values which pass unclamped, and its function code chooses its behaviour.
// - Governor and regulator codes scale the span between low and high percent limits.
// - Code 0102 drives the output only from the serially commanded value.
// - Output codes decode into unused, serial, governor, regulator and measurement kinds.
// - Codes 3101, 3111, 3121, 3201, 3211 and 3221 scale the chosen measurement only through the attached curve.
module tcaio_top #(
   parameter int TICK_CYCLES = tcaio_pkg::TICK_CYC
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [tcaio_pkg::NMEAS*tcaio_pkg::VAL_W-1:0] meas,
   input wire logic [tcaio_pkg::NIN*tcaio_pkg::VAL_W-1:0] phys_in,
   input wire logic signed [tcaio_pkg::VAL_W-1:0] gov_cmd,
   input wire logic signed [tcaio_pkg::VAL_W-1:0] avr_cmd,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic [tcaio_pkg::NIN-1:0] in_status,
   output logic signed [tcaio_pkg::VAL_W-1:0] analog_out_one,
   output logic signed [tcaio_pkg::VAL_W-1:0] analog_out_two,
   output logic irq
);
   import tcaio_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [$clog2(TICK_CYCLES+1)-1:0] div;
      logic tick;
      logic [NIN-1:0][CODE_W-1:0] ifunc;
      logic [NIN-1:0] virt;
      logic [NIN-1:0][1:0][VAL_W-1:0] thr;
      logic [NIN-1:0][1:0][DLY_W-1:0] dly;
      logic [NIN-1:0][1:0][1:0] cfg;
      logic [NIN-1:0] in_curve;
      logic [NIN-1:0] st;
      logic [1:0][CODE_W-1:0] ofunc;
      logic [1:0][7:0] lim_gov;
      logic [1:0][7:0] lim_avr;
      logic [1:0][VAL_W-1:0] ser;
      logic [1:0][VAL_W-1:0] aout;
      logic [NCURVE-1:0][NPTS-1:0][VAL_W-1:0] cx;
      logic [NCURVE-1:0][NPTS-1:0][VAL_W-1:0] cy;
      logic [NCURVE-1:0][PIDX_W:0] cn;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] imask;
      logic [31:0] rdata;
      logic irq;
   } tcaio_st_t;
   tcaio_st_t s, next_s;

   function automatic logic signed [VAL_W-1:0] pick_meas(input logic [CODE_W-1:0] code);
      pick_meas = $signed(meas[(int'(code) % NMEAS)*VAL_W +: VAL_W]);
   endfunction

   // Output kind decode, used for both channels
   function automatic logic [2:0] out_kind(input logic [CODE_W-1:0] code);
      case (code)
         OF_SERIAL: out_kind = 3'h1;
         OF_GOV: out_kind = 3'h2;
         OF_GOV_C: out_kind = 3'h3;
         OF_AVR: out_kind = 3'h4;
         OF_AVR_C: out_kind = 3'h5;
         OF_BUS_F, OF_BUS_V, OF_BUS_P, OF_MNS_F, OF_MNS_V, OF_MNS_P: out_kind = 3'h6;
         default: out_kind = 3'h0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Input values, thresholds and curves
   // ----------------------------------------------------------------
   logic signed [VAL_W-1:0] raw_in [NIN];
   logic signed [VAL_W-1:0] in_val [NIN];
   logic signed [VAL_W-1:0] crv_in [NCURVE];
   logic signed [VAL_W-1:0] crv_out [NCURVE];
   logic [NIN-1:0][1:0] fire;

   genvar gi, gt;
   generate
      for (gi = 0; gi < NIN; gi++) begin : g_in
         always_comb begin
            if (s.virt[gi] && s.ifunc[gi] >= IN_VIRT_MIN) begin
               raw_in[gi] = pick_meas(s.ifunc[gi]);
            end else if (!s.virt[gi] && s.ifunc[gi] != OF_UNUSED) begin
               raw_in[gi] = $signed(phys_in[gi*VAL_W +: VAL_W]);
            end else begin
               raw_in[gi] = '0;
            end
            // Curve 0 serves input 0 only; the curve bit of the other inputs is ignored
            in_val[gi] = (s.in_curve[gi] && gi == 0) ? crv_out[0] : raw_in[gi];
         end
         for (gt = 0; gt < 2; gt++) begin : g_th
            tcaio_thresh #(.VW(VAL_W), .DW(DLY_W)) u_th (
               .clk(clk),
               .nrst(nrst),
               .tick(s.tick),
               .value(in_val[gi]),
               .level(s.thr[gi][gt]),
               .delay(s.dly[gi][gt]),
               .below(s.cfg[gi][gt][CFG_BELOW]),
               .fire(fire[gi][gt])
            );
         end
      end
      for (gi = 0; gi < NCURVE; gi++) begin : g_crv
         tcaio_curve #(.VW(VAL_W), .NP(NPTS), .IW(PIDX_W)) u_crv (
            .x(crv_in[gi]),
            .px(s.cx[gi]),
            .py(s.cy[gi]),
            .npts(s.cn[gi]),
            .y(crv_out[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Output channel compute
   // ----------------------------------------------------------------
   logic signed [VAL_W-1:0] chan_mv [2];
   logic signed [VAL_W-1:0] chan_pct [2];
   logic [7:0] lo_l [2];
   logic [7:0] hi_l [2];
   logic signed [31:0] span [2];

   always_comb begin
      crv_in[0] = s.in_curve[0] ? raw_in[0] : pick_meas(s.ofunc[0]);
      crv_in[1] = pick_meas(s.ofunc[1]);
      for (int c = 0; c < 2; c++) begin
         lo_l[c] = LIM_LO_RST;
         hi_l[c] = LIM_HI_RST;
         chan_pct[c] = '0;
         chan_mv[c] = '0;
         span[c] = '0;
         case (out_kind(s.ofunc[c]))
            3'h1: chan_mv[c] = $signed(s.ser[c]);
            3'h2, 3'h3: begin
               chan_pct[c] = (out_kind(s.ofunc[c]) == 3'h3) ? crv_out[c] : gov_cmd;
               lo_l[c] = s.lim_gov[0];
               hi_l[c] = s.lim_gov[1];
            end
            3'h4, 3'h5: begin
               chan_pct[c] = (out_kind(s.ofunc[c]) == 3'h5) ? crv_out[c] : avr_cmd;
               lo_l[c] = s.lim_avr[0];
               hi_l[c] = s.lim_avr[1];
            end
            3'h6: chan_pct[c] = crv_out[c];
            default: chan_mv[c] = '0;
         endcase
         if (out_kind(s.ofunc[c]) inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h6}) begin
            // Percent p within limits maps to -10 V at 0 % and +10 V at 100 % of full span
            span[c] = 32'(signed'({1'b0, lo_l[c]})) * 32'sd100
               + (32'(signed'({1'b0, hi_l[c]})) - 32'(signed'({1'b0, lo_l[c]})))
               * 32'(chan_pct[c]);
            span[c] = span[c] * 32'(OUT_FULL_MV) * 32'sd2 / (32'(PCT_FULL) * 32'sd100)
               - 32'(OUT_FULL_MV);
            if (span[c] > 32'(OUT_FULL_MV)) begin
               span[c] = 32'(OUT_FULL_MV);
            end else if (span[c] < -32'(OUT_FULL_MV)) begin
               span[c] = -32'(OUT_FULL_MV);
            end
            chan_mv[c] = VAL_W'(span[c]);
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   logic [IRQ_W-1:0] ev;
   logic [7:0] wi;

   always_comb begin
      next_s = s;
      ev = '0;
      wi = addr - A_IFUNC;
      next_s.tick = 1'b0;
      if (32'(s.div) >= TICK_CYCLES - 1) begin
         next_s.div = '0;
         next_s.tick = 1'b1;
      end else begin
         next_s.div = s.div + 1'b1;
      end
      for (int i = 0; i < NIN; i++) begin
         for (int t = 0; t < 2; t++) begin
            if (fire[i][t]) begin
               next_s.st[i] = s.cfg[i][t][CFG_SET];
            end
         end
         ev[i] = next_s.st[i] & ~s.st[i];
      end
      if (s.tick) begin
         next_s.aout[0] = chan_mv[0];
         next_s.aout[1] = chan_mv[1];
         ev[NIN+1] = 1'b1;
      end
      next_s.rdata = '0;
      if (wr) begin
         if (addr >= A_IFUNC && addr < A_IFUNC + 8'(NIN*4)) begin
            next_s.virt[wi[3:2]] = wdata[31];
            if (!wdata[31] && wdata[CODE_W-1:0] > IN_PHYS_MAX) begin
               next_s.ifunc[wi[3:2]] = OF_UNUSED;
               ev[NIN] = 1'b1;
            end else begin
               next_s.ifunc[wi[3:2]] = wdata[CODE_W-1:0];
            end
            next_s.in_curve[wi[3:2]] = wdata[30];
         end else if (addr >= A_THR && addr < A_THR + 8'(NIN*8)) begin
            wi = addr - A_THR;
            next_s.thr[wi[4:3]][wi[2]] = wdata[VAL_W-1:0];
            next_s.dly[wi[4:3]][wi[2]] = DLY_W'(wdata[23:16]);
            next_s.cfg[wi[4:3]][wi[2]] = wdata[31:30];
         end else if (addr[7:6] == A_CURVE[7:6] + 2'h1 || addr >= A_CURVE) begin
            // Point write: addr[2] picks curve, wdata[28:24] the point, wdata[31] set loads count from wdata[29:24]
            next_s.cx[addr[2]][wdata[28:24]] = {8'h00, wdata[23:16]} ^ {VAL_W{wdata[29]}};
            next_s.cy[addr[2]][wdata[28:24]] = wdata[VAL_W-1:0];
            if (wdata[31]) begin
               next_s.cn[addr[2]] = wdata[29:24];
            end
         end else begin
            case (addr)
               A_IRQ_ST: next_s.ist = s.ist & ~wdata[IRQ_W-1:0];
               A_IRQ_MASK: next_s.imask = wdata[IRQ_W-1:0];
               A_OFUNC0: next_s.ofunc[0] = wdata[CODE_W-1:0];
               A_OFUNC1: next_s.ofunc[1] = wdata[CODE_W-1:0];
               A_LIM_GOV: next_s.lim_gov = wdata[15:0];
               A_LIM_AVR: next_s.lim_avr = wdata[15:0];
               A_SER0: next_s.ser[0] = wdata[VAL_W-1:0];
               A_SER1: next_s.ser[1] = wdata[VAL_W-1:0];
               default: next_s.ist = next_s.ist;
            endcase
         end
      end
      if (rd) begin
         case (addr)
            A_STATUS: next_s.rdata = 32'(s.st);
            A_IRQ_ST: next_s.rdata = 32'(s.ist);
            A_IRQ_MASK: next_s.rdata = 32'(s.imask);
            A_OFUNC0: next_s.rdata = 32'(s.ofunc[0]);
            A_OFUNC1: next_s.rdata = 32'(s.ofunc[1]);
            A_LIM_GOV: next_s.rdata = 32'(s.lim_gov);
            A_LIM_AVR: next_s.rdata = 32'(s.lim_avr);
            A_SER0: next_s.rdata = 32'(s.ser[0]);
            A_SER1: next_s.rdata = 32'(s.ser[1]);
            A_OUT0: next_s.rdata = 32'(s.aout[0]);
            A_OUT1: next_s.rdata = 32'(s.aout[1]);
            default: next_s.rdata = (addr >= A_IFUNC && addr < A_IFUNC + 8'(NIN*4)) ?
               {s.virt[addr[3:2]], s.in_curve[addr[3:2]], 16'h0000, s.ifunc[addr[3:2]]} : '0;
         endcase
      end
      // Set wins over a clear in the same cycle
      next_s.ist = next_s.ist | ev;
      next_s.irq = |(next_s.ist & next_s.imask);
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         s <= '0;
         s.lim_gov <= {LIM_HI_RST, LIM_LO_RST};
         s.lim_avr <= {LIM_HI_RST, LIM_LO_RST};
         for (int i = 0; i < NIN; i++) begin
            s.dly[i] <= {DLY_W'(DEF_DELAY_TICKS), DLY_W'(DEF_DELAY_TICKS)};
         end
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign in_status = s.st;
   assign analog_out_one = s.aout[0];
   assign analog_out_two = s.aout[1];
   assign irq = s.irq;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_phys_refuse;
      @(posedge clk) disable iff (!nrst)
         wr && addr >= A_IFUNC && addr < A_IFUNC + 8'(NIN*4) && !wdata[31]
         && wdata[CODE_W-1:0] > IN_PHYS_MAX
         |=> s.ifunc[$past(addr[3:2])] == OF_UNUSED && s.ist[NIN];
   endproperty
   a_phys_refuse: assert property (p_phys_refuse) else $error("code above 4000 kept");
   property p_serial_out;
      @(posedge clk) disable iff (!nrst)
         s.tick && s.ofunc[0] == OF_SERIAL |=> analog_out_one == $past(s.ser[0]);
   endproperty
   a_serial_out: assert property (p_serial_out) else $error("serial value not driven");
   property p_range;
      @(posedge clk) disable iff (!nrst)
         s.ofunc[1] != OF_SERIAL |-> ##1 (analog_out_two <= OUT_FULL_MV
         && analog_out_two >= -OUT_FULL_MV) || $past(s.ofunc[1]) == OF_SERIAL;
   endproperty
   a_range: assert property (p_range) else $error("output outside span");
   property p_status_hold;
      @(posedge clk) disable iff (!nrst)
         !(|fire[1]) |=> $stable(s.st[1]);
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status moved unprompted");

   property p_tick_period;
      @(posedge clk) disable iff (!nrst)
         s.tick |=> !s.tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("tick longer than a cycle");

   property p_irq_level;
      @(posedge clk) disable iff (!nrst)
         irq == |(s.ist & s.imask);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

   property p_unused_zero;
      @(posedge clk) disable iff (!nrst)
         s.tick && s.ofunc[0] == OF_UNUSED |=> analog_out_one == 16'sd0;
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused output not zero");

   property p_set_action;
      @(posedge clk) disable iff (!nrst)
         fire[0][0] && !fire[0][1] |=> s.st[0] == $past(s.cfg[0][0][CFG_SET]);
   endproperty
   a_set_action: assert property (p_set_action) else $error("threshold action wrong");
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the threshold, curve and analogue output block
`timescale 1ns/1ns
module tb_top;
   import tcaio_pkg::*;
   localparam int TK = 10;
   typedef struct {
      logic [CODE_W-1:0] code;
      logic [15:0] lim;
      logic signed [15:0] pct;
      logic signed [15:0] ser;
      logic signed [15:0] exp;
   } tcaio_row_t;
   logic clk, nrst, wr, rd, irq, err1, err2;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [NMEAS*VAL_W-1:0] meas;
   logic [NIN*VAL_W-1:0] phys_in;
   logic signed [VAL_W-1:0] gov_cmd, avr_cmd, out1, out2;
   logic [NIN-1:0] in_status;
   int n_fail, n_tests, cyc;
   // Limits are {hi,lo} percent; non-serial rows carry a serial decoy
   tcaio_row_t rows [8] = '{
      '{OF_GOV, 16'h6432, 100, 777, 10000},
      '{OF_GOV, 16'h6432, 0, 777, 0},
      '{OF_GOV, 16'h4b32, 100, 777, 5000},
      '{OF_GOV, 16'h3c28, 0, 777, -2000},
      '{OF_AVR, 16'h3c28, 100, 777, 2000},
      '{OF_AVR, 16'h6400, 50, 777, 0},
      '{OF_SERIAL, 16'h6432, 100, -10000, -10000},
      '{OF_UNUSED, 16'h6432, 100, 777, 0}};
   tcaio_top #(.TICK_CYCLES(TK)) u_tcaio_top (.clk(clk), .nrst(nrst), .meas(meas),
      .phys_in(phys_in), .gov_cmd(gov_cmd), .avr_cmd(avr_cmd), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .in_status(in_status),
      .analog_out_one(out1), .analog_out_two(out2), .irq(irq));
   tcaio_act_model u_gov (.clk(clk), .nrst(nrst), .drive_mv(out1), .range_err(err1));
   tcaio_act_model u_avr (.clk(clk), .nrst(nrst), .drive_mv(out2), .range_err(err2));
   // ----------------------------------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         n_fail = n_fail + 1;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Fixed waits of whole ticks; the excursion timer counts ticks
   task automatic wait_tk(input int n);
      repeat (n * TK) @(posedge clk);
      #1;
   endtask
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {nrst, wr, rd, addr, wdata, meas, phys_in, gov_cmd, avr_cmd} = '0;
      n_fail = 0;
      n_tests = 0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      #1 chk(out1, 0);
      chk(irq, 0);
      rd_reg(A_LIM_GOV, d);
      chk(d, 32'h00006400);
      rd_reg(8'hfc, d);
      chk(d, 0);
      foreach (rows[i]) begin
         wr_reg(A_OFUNC0, {18'h0, rows[i].code});
         wr_reg(A_OFUNC1, {18'h0, rows[i].code});
         wr_reg(A_LIM_GOV, {16'h0, rows[i].lim});
         wr_reg(A_LIM_AVR, {16'h0, rows[i].lim});
         wr_reg(A_SER0, {{16{rows[i].ser[15]}}, rows[i].ser});
         wr_reg(A_SER1, {{16{rows[i].ser[15]}}, rows[i].ser});
         gov_cmd <= rows[i].pct;
         avr_cmd <= rows[i].pct;
         wait_tk(3);
         chk(out1, rows[i].exp);
         chk(out2, rows[i].exp);
      end
      // Curve 1 on output two: (0,10) to (100,90); the bus frequency code picks measurement 5
      wr_reg(A_CURVE + 8'h04, 32'h0000000a);
      wr_reg(A_CURVE + 8'h04, 32'h0164005a);
      wr_reg(A_CURVE + 8'h04, 32'h82000000);
      wr_reg(A_OFUNC1, {18'h0, OF_BUS_F});
      meas[95:80] <= 16'd25;
      wait_tk(3);
      chk(out2, -4000);
      meas[95:80] <= 16'd110;
      wait_tk(3);
      chk(out2, 9600);
      // Input 0: set above 100, clear below 50, both after 3 ticks
      wr_reg(A_IFUNC, 32'd2051);
      wr_reg(A_THR, {2'b10, 6'h0, 8'd3, 16'd100});
      wr_reg(A_THR + 8'h04, {2'b01, 6'h0, 8'd3, 16'd50});
      wr_reg(A_IRQ_ST, 32'h3f);
      wr_reg(A_IRQ_MASK, 32'h01);
      phys_in[15:0] <= 16'd200;
      wait_tk(2);
      phys_in[15:0] <= 16'd75;
      wait_tk(8);
      chk(in_status[0], 0);
      phys_in[15:0] <= 16'd200;
      wait_tk(8);
      chk(in_status[0], 1);
      chk(irq, 1);
      wr_reg(A_IRQ_ST, 32'h01);
      settle();
      chk(irq, 0);
      phys_in[15:0] <= 16'd75;
      wait_tk(8);
      chk(in_status[0], 1);
      phys_in[15:0] <= 16'd10;
      wait_tk(8);
      chk(in_status[0], 0);
      // Virtual input 1 follows measurement 1, its physical reading stays 0
      meas[31:16] <= 16'd300;
      wr_reg(A_IFUNC + 8'h04, {1'b1, 17'h0, 14'd4001});
      wr_reg(A_THR + 8'h08, {2'b10, 6'h0, 8'd3, 16'd100});
      wait_tk(8);
      chk(in_status[1], 1);
      wr_reg(A_IRQ_MASK, 32'h10);
      wr_reg(A_IFUNC + 8'h08, 32'd4005);
      rd_reg(A_IFUNC + 8'h08, d);
      chk(d[13:0], 0);
      settle();
      chk(irq, 1);
      wr_reg(A_IFUNC + 8'h0c, 32'd4000);
      rd_reg(A_IFUNC + 8'h0c, d);
      chk(d[13:0], 14'd4000);
      wr_reg(A_IRQ_ST, 32'h10);
      settle();
      chk(irq, 0);
      // Output one carries the serial value, so the reset below has something to clear
      wr_reg(A_OFUNC0, {18'h0, OF_SERIAL});
      wait_tk(2);
      chk(out1, 777);
      // Second reset in mid-run
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      #1 chk(in_status, 0);
      chk(out1, 0);
      chk({err2, err1}, 0);
      rd_reg(A_LIM_GOV, d);
      chk(d, 32'h00006400);
      close_out();
   end
endmodule

// ==== testbench/tcaio_act_model.sv ====
// Behavioural actuator input watching one analogue output command
`timescale 1ns/1ns
module tcaio_act_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic signed [tcaio_pkg::VAL_W-1:0] drive_mv,
   output logic range_err
);
   import tcaio_pkg::*;
   // ----------------------------------------------------------------
   // Range watch
   // ----------------------------------------------------------------
   // Sticky, so a single overshoot between bench samples is not lost
   always_ff @(posedge clk) begin
      if (!nrst) begin
         range_err <= 1'b0;
      end else if (drive_mv > OUT_FULL_MV || drive_mv < -OUT_FULL_MV) begin
         range_err <= 1'b1;
      end
   end
endmodule
